// >>> vpsq_pkg.sv
//==============================================================
// Purpose: shared constants and types of the vector sequencer
// Assumes: one 50 MHz clock, inputs synchronous to it
// Notes:   indices are 1-based outside, 0-based in storage
package vpsq_pkg;
    //==========================================================
    // sizes and limits
    localparam int             NPINS    = 40;          // driven pins
    localparam int             ADDR_W   = 13;          // storage index
    localparam int             IDX_W    = 14;          // host index
    localparam int             LCNT_W   = 17;          // loop count
    localparam int             DIV_W    = 16;          // freq divider
    localparam logic [13:0]    IDX_MIN  = 14'h0001;    // first index
    localparam logic [13:0]    IDX_MAX  = 14'h2000;    // last index
    localparam logic [16:0]    LCNT_MIN = 17'h0_0001;  // least count
    localparam logic [16:0]    LCNT_MAX = 17'h1_0000;  // most count
    localparam logic [16:0]    LCNT_ONE = 17'h0_0001;  // last pass
    localparam logic [12:0]    ADDR_ONE = 13'h0001;    // index step
    localparam logic [15:0]    DIV_ZERO = 16'h0000;    // divider start

    //==========================================================
    // enumerations
    typedef enum logic [1:0] {
        SRC_DRCLK, SRC_INTFREQ, SRC_STEP, SRC_POD
    } vpsq_src_e;                                      // drive clock
    typedef enum logic [1:0] {
        ST_IDLE, ST_RUN, ST_PAUSE, ST_DONE
    } vpsq_state_e;                                    // sequencer

    //==========================================================
    // carriers
    typedef struct packed {
        logic [NPINS-1:0] level;      // 1 high, 0 low
        logic [NPINS-1:0] drive;      // 0 means tri-state
        logic             stop;       // stop after this vector
        logic             capture;    // single capture
        logic             cap_on;     // capture run begins here
        logic             cap_off;    // capture run ends here
        logic             wait_mark;  // pause before this vector
    } vpsq_vec_s;
    typedef struct packed {
        vpsq_vec_s        vec;        // vector contents
        logic [IDX_W-1:0] index;      // 1..8192
        logic             loop_first; // first vector of loop
        logic             loop_last;  // last vector of loop
        logic             wait_rise;  // wait edge polarity
    } vpsq_load_s;
    typedef struct packed {
        logic drclk;                  // external drive clock
        logic step;                   // software step strobe
        logic pod;                    // probe pod clock
        logic enable;                 // drive clock qualifier
    } vpsq_clk_s;
endpackage : vpsq_pkg

// >>> vpsq_top.sv
//==============================================================
// Purpose: vector pattern sequencer driving 40 pins
// Assumes: host loads vectors, then starts driving
// Notes:   drive clocks arrive as synchronous levels
//
// Contract
// - one high, zero low, X tri-state
// - forty pin values applied together
// - start index 1..8192, else rejected
// - loop count 1..65536 accepted
// - loop repeats count times, one plain
// - one loop pair, two vectors min
// - stop ends after preceding vector; the code stops after driving the stop vector itself
// - stop before endloop waits loop end
// - capture on opposite drive clock edge
// - repeated capture markers, one strobe
// - capture run strobes every vector
// - internal sources always yield capture
// - wait marker pauses until chosen edge
// - mixed wait polarities rejected
// - start inside loop wraps to first
// - four selectable drive clock sources
// - qualifier off holds ext/intfreq index
`timescale 1ns/1ns
module vpsq_top (
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    input  wire logic                       load_valid_i,
    input  wire vpsq_pkg::vpsq_load_s       load_i,
    input  wire logic                       pat_clear_i,
    input  wire logic [vpsq_pkg::LCNT_W-1:0] loop_count_i,
    input  wire vpsq_pkg::vpsq_src_e        src_i,
    input  wire vpsq_pkg::vpsq_clk_s        clk_src_i,
    input  wire logic [vpsq_pkg::DIV_W-1:0] freq_div_i,
    input  wire logic                       wait_i,
    input  wire logic                       start_i,
    input  wire logic [vpsq_pkg::IDX_W-1:0] start_index_i,
    output logic [vpsq_pkg::NPINS-1:0]      pins_o,
    output logic [vpsq_pkg::NPINS-1:0]      pins_oe_o,
    output logic                            capture_o,
    output logic                            busy_o,
    output logic                            done_o,
    output logic                            start_err_o,
    output logic                            pattern_err_o
);
    //==========================================================
    // helpers
    // edge of a level against its last value
    function automatic logic edge_of(input logic now, input logic was,
                                     input logic rising);
        edge_of = rising ? (now & ~was) : (~now & was);
    endfunction : edge_of
    // host index inside 1..8192
    function automatic logic idx_ok(input logic [13:0] idx);
        idx_ok = (idx >= vpsq_pkg::IDX_MIN) && (idx <= vpsq_pkg::IDX_MAX);
    endfunction : idx_ok

    //==========================================================
    // state
    vpsq_pkg::vpsq_vec_s   mem_q [2**vpsq_pkg::ADDR_W]; // vector store
    vpsq_pkg::vpsq_state_e st_q;                        // sequencer
    logic [12:0]           cur_q;                       // next to drive
    logic [12:0]           last_q;                      // highest loaded
    logic [12:0]           loop_first_q, loop_last_q;   // loop bounds
    logic                  lf_seen_q, ll_seen_q;        // loop marks
    logic                  any_q;                       // pattern loaded
    logic                  wseen_q, wpol_q;             // wait polarity
    logic [16:0]           rem_q;                       // passes left
    logic                  cap_mode_q, cap_pend_q;      // capture state
    logic                  drclk_q, pod_q, step_q;      // last levels
    logic                  step_dly_q, gen_q, wait_q;
    logic [15:0]           div_q;                       // freq divider

    //==========================================================
    // decode
    wire       load_we  = load_valid_i && !busy_o && idx_ok(load_i.index);
    wire [12:0] load_a  = load_i.index[12:0] - vpsq_pkg::ADDR_ONE;
    wire [12:0] start_a = start_index_i[12:0] - vpsq_pkg::ADDR_ONE;
    wire       gen_tick = div_q >= freq_div_i;
    wire       gen_rise = gen_tick && !gen_q;
    wire       gen_fall = gen_tick && gen_q;
    wire       has_loop = lf_seen_q && ll_seen_q;
    // pick the advancing edge; qualifier gates two
    logic advance, opposite;
    always_comb begin
        case (src_i)
            vpsq_pkg::SRC_DRCLK: begin
                advance  = edge_of(clk_src_i.drclk, drclk_q, 1'b1)
                           && clk_src_i.enable;
                opposite = edge_of(clk_src_i.drclk, drclk_q, 1'b0);
            end
            vpsq_pkg::SRC_INTFREQ: begin
                advance  = gen_rise && clk_src_i.enable;
                opposite = gen_fall;
            end
            vpsq_pkg::SRC_STEP: begin
                advance  = edge_of(clk_src_i.step, step_q, 1'b1);
                opposite = step_dly_q;
            end
            default: begin
                advance  = edge_of(clk_src_i.pod, pod_q, 1'b1);
                opposite = edge_of(clk_src_i.pod, pod_q, 1'b0);
            end
        endcase
    end
    wire vpsq_pkg::vpsq_vec_s cur_v = mem_q[cur_q];
    wire loop_end   = has_loop && (cur_q == loop_last_q);
    wire loop_again = loop_end && (rem_q > vpsq_pkg::LCNT_ONE);
    wire stop_now   = cur_v.stop && !loop_again;
    wire at_end     = (cur_q == last_q) && !loop_again;
    // wrap from loop end to loop first, wherever started
    wire [12:0] nxt_a = loop_again ? loop_first_q : cur_q + vpsq_pkg::ADDR_ONE;
    wire nxt_wait   = mem_q[nxt_a].wait_mark;
    // one strobe per vector, marked or in a run
    wire cap_this   = cur_v.capture | cur_v.cap_on
                      | (cap_mode_q & ~cur_v.cap_off);
    wire wait_edge  = edge_of(wait_i, wait_q, wpol_q);
    wire cnt_ok     = (loop_count_i >= vpsq_pkg::LCNT_MIN)
                      && (loop_count_i <= vpsq_pkg::LCNT_MAX);
    wire shape_ok   = (lf_seen_q == ll_seen_q)
                      && (!has_loop || loop_last_q > loop_first_q);
    wire start_ok   = idx_ok(start_index_i) && cnt_ok && shape_ok
                      && any_q && !pattern_err_o && (start_a <= last_q);
    wire run_adv    = (st_q == vpsq_pkg::ST_RUN) && advance;

    //==========================================================
    // vector store, written only while not busy (idle or done)
    always_ff @(posedge clk_i) begin
        if (load_we) begin
            mem_q[load_a] <= load_i.vec;
        end
    end

    //==========================================================
    // clock source tracking and internal frequency generator
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drclk_q    <= 1'b0;
            pod_q      <= 1'b0;
            step_q     <= 1'b0;
            step_dly_q <= 1'b0;
            wait_q     <= 1'b0;
            gen_q      <= 1'b0;
            div_q      <= vpsq_pkg::DIV_ZERO;
        end else begin
            drclk_q    <= clk_src_i.drclk;
            pod_q      <= clk_src_i.pod;
            step_q     <= clk_src_i.step;
            step_dly_q <= edge_of(clk_src_i.step, step_q, 1'b1);
            wait_q     <= wait_i;
            div_q      <= gen_tick ? vpsq_pkg::DIV_ZERO : div_q + 16'h0001;
            gen_q      <= gen_q ^ gen_tick;
        end
    end

    //==========================================================
    // pattern bookkeeping on load
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {lf_seen_q, ll_seen_q, any_q, wseen_q, wpol_q} <= 5'h00;
            loop_first_q  <= 13'h0000;
            loop_last_q   <= 13'h0000;
            last_q        <= 13'h0000;
            pattern_err_o <= 1'b0;
        end else if (pat_clear_i && !busy_o) begin
            {lf_seen_q, ll_seen_q, any_q, wseen_q, wpol_q} <= 5'h00;
            last_q        <= 13'h0000;
            pattern_err_o <= load_valid_i && !load_we;    // bad load wins
        end else if (load_valid_i && !busy_o) begin
            if (!load_we) begin
                pattern_err_o <= 1'b1;
            end else begin
                any_q  <= 1'b1;
                last_q <= (!any_q || load_a > last_q) ? load_a : last_q;
                // a second loop pair is an error
                if (load_i.loop_first) begin
                    if (lf_seen_q && load_a != loop_first_q) begin
                        pattern_err_o <= 1'b1;
                    end
                    lf_seen_q    <= 1'b1;
                    loop_first_q <= load_a;
                end
                if (load_i.loop_last) begin
                    if (ll_seen_q && load_a != loop_last_q) begin
                        pattern_err_o <= 1'b1;
                    end
                    ll_seen_q   <= 1'b1;
                    loop_last_q <= load_a;
                end
                // all wait marks share one polarity
                if (load_i.vec.wait_mark) begin
                    if (wseen_q && wpol_q != load_i.wait_rise) begin
                        pattern_err_o <= 1'b1;
                    end
                    wseen_q <= 1'b1;
                    wpol_q  <= load_i.wait_rise;
                end
            end
        end
    end

    //==========================================================
    // sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q        <= vpsq_pkg::ST_IDLE;
            cur_q       <= 13'h0000;
            rem_q       <= vpsq_pkg::LCNT_ONE;
            cap_mode_q  <= 1'b0;
            pins_o      <= '0;
            pins_oe_o   <= '0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            start_err_o <= 1'b0;
        end else begin
            start_err_o <= start_i && (busy_o || !start_ok);
            case (st_q)
                vpsq_pkg::ST_IDLE, vpsq_pkg::ST_DONE: begin
                    if (start_i && start_ok) begin
                        cur_q      <= start_a;
                        rem_q      <= loop_count_i;
                        cap_mode_q <= 1'b0;
                        busy_o     <= 1'b1;
                        done_o     <= 1'b0;
                        st_q       <= mem_q[start_a].wait_mark ?
                                      vpsq_pkg::ST_PAUSE : vpsq_pkg::ST_RUN;
                    end
                end
                vpsq_pkg::ST_RUN: begin
                    if (advance) begin
                        pins_o     <= cur_v.level;
                        pins_oe_o  <= cur_v.drive;
                        cap_mode_q <= cur_v.cap_on | (cap_mode_q & ~cur_v.cap_off);
                        if (loop_again) begin
                            rem_q <= rem_q - vpsq_pkg::LCNT_ONE;
                        end
                        if (stop_now || at_end) begin
                            st_q   <= vpsq_pkg::ST_DONE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end else begin
                            cur_q <= nxt_a;
                            st_q  <= nxt_wait ? vpsq_pkg::ST_PAUSE
                                              : vpsq_pkg::ST_RUN;
                        end
                    end
                end
                vpsq_pkg::ST_PAUSE: begin
                    if (wait_edge) begin
                        st_q <= vpsq_pkg::ST_RUN;
                    end
                end
                default: st_q <= vpsq_pkg::ST_IDLE;
            endcase
        end
    end

    //==========================================================
    // capture strobe on the opposite edge, set wins over clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_pend_q <= 1'b0;
            capture_o  <= 1'b0;
        end else begin
            capture_o  <= cap_pend_q && opposite;
            cap_pend_q <= (run_adv && cap_this) || (cap_pend_q && !opposite);
        end
    end

    //==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_step_drive;
        run_adv && cap_this && src_i == vpsq_pkg::SRC_STEP;
    endsequence
    sequence s_capture_seen;
        !capture_o ##1 capture_o;
    endsequence

    property p_drive;
        run_adv |=> pins_o == $past(cur_v.level) && pins_oe_o == $past(cur_v.drive);
    endproperty
    a_drive: assert property (p_drive) else $error("pins differ");
    property p_bad_start;
        start_i && !start_ok |=> start_err_o && !$rose(busy_o);
    endproperty
    a_bad_start: assert property (p_bad_start) else $error("bad start taken");
    property p_wrap;
        run_adv && loop_again |=> cur_q == $past(loop_first_q)
                                  && rem_q == $past(rem_q) - vpsq_pkg::LCNT_ONE;
    endproperty
    a_wrap: assert property (p_wrap) else $error("loop did not wrap");
    property p_stop;
        run_adv && stop_now |=> st_q == vpsq_pkg::ST_DONE && done_o && !busy_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_stop_loop;
        run_adv && cur_v.stop && loop_again |=> st_q != vpsq_pkg::ST_DONE;
    endproperty
    a_stop_loop: assert property (p_stop_loop) else $error("early stop");
    property p_step_cap;
        s_step_drive |-> ##1 !capture_o ##1 capture_o;
    endproperty
    a_step_cap: assert property (p_step_cap) else $error("no step capture");
    property p_one_strobe;
        s_capture_seen |=> !capture_o;
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("double strobe");
    property p_pause;
        st_q == vpsq_pkg::ST_PAUSE && !wait_edge |=>
            st_q == vpsq_pkg::ST_PAUSE && $stable(pins_o) && $stable(cur_q);
    endproperty
    a_pause: assert property (p_pause) else $error("pause leaked");
    property p_gate;
        st_q == vpsq_pkg::ST_RUN && !clk_src_i.enable
        && (src_i == vpsq_pkg::SRC_DRCLK || src_i == vpsq_pkg::SRC_INTFREQ)
        |=> $stable(cur_q) && $stable(pins_o);
    endproperty
    a_gate: assert property (p_gate) else $error("gated clock advanced");
    property p_done_hold;
        st_q == vpsq_pkg::ST_DONE && !start_i |=> $stable(pins_o) && done_o;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done not held");
    property p_wait_mix;
        load_we && load_i.vec.wait_mark && wseen_q && !pat_clear_i
        && wpol_q != load_i.wait_rise |=> pattern_err_o;
    endproperty
    a_wait_mix: assert property (p_wait_mix) else $error("mixed waits kept");
endmodule : vpsq_top

// >>> vpsq_uut_model.sv
//==============================================================
// Purpose: board under test seen from the forty driven pins
// Assumes: no pull resistors, an undriven pin floats
// Notes:   counts capture strobes and owns the pause line
`timescale 1ns/1ns
module vpsq_uut_model (
    input  wire logic                       clk_i,
    input  wire logic [vpsq_pkg::NPINS-1:0] pins_i,
    input  wire logic [vpsq_pkg::NPINS-1:0] pins_oe_i,
    input  wire logic                       capture_i,
    output logic                            wait_o,
    output wire [vpsq_pkg::NPINS-1:0]       bus_o
);
    int cap_count; // strobes seen so far
    //==========================================================
    // pin resolution: a pin without enable floats
    for (genvar i = 0; i < vpsq_pkg::NPINS; i++) begin : g_pin
        assign bus_o[i] = pins_oe_i[i] ? pins_i[i] : 1'bz;
    end
    initial begin
        wait_o = 1'b0;
        cap_count = 0;
    end
    // strobe counter, sampled on the rising edge
    always @(posedge clk_i) begin
        if (capture_i === 1'b1) begin
            cap_count <= cap_count + 1;
        end
    end
    // one level change on the pause line, off the sampling edge
    task automatic flip_wait();
        @(negedge clk_i) wait_o = ~wait_o;
    endtask : flip_wait
endmodule : vpsq_uut_model

// >>> test_vector_pattern_sequencer.sv
//==============================================================
// Purpose: self-checking bench of the vector sequencer
// Assumes: drive clocks are levels changed at the falling edge
// Notes:   vector n carries its own index in both halves
`timescale 1ns/1ns
module test_vector_pattern_sequencer;
    localparam logic [8:0] F_TRI = 9'h001, F_WR = 9'h002, F_WM = 9'h004;
    localparam logic [8:0] F_COF = 9'h008, F_CON = 9'h010, F_CAP = 9'h020;
    localparam logic [8:0] F_STP = 9'h040, F_LL = 9'h080, F_LF = 9'h100;
    logic                  clk_i = 1'b0;
    logic                  resetn_i = 1'b0;
    logic                  load_valid_i = 1'b0;
    vpsq_pkg::vpsq_load_s  load_i = '0;
    logic                  pat_clear_i = 1'b0;
    logic [16:0]           loop_count_i = 17'h0_0001;
    vpsq_pkg::vpsq_src_e   src_i = vpsq_pkg::SRC_STEP;
    vpsq_pkg::vpsq_clk_s   clk_src_i = '0;
    logic [15:0]           freq_div_i = 16'h0003;
    logic                  start_i = 1'b0;
    logic [13:0]           start_index_i = 14'h0001;
    logic                  wait_i;
    logic [39:0]           pins_o, pins_oe_o;
    wire  [39:0]           bus;
    logic                  capture_o, busy_o, done_o, start_err_o, pattern_err_o;
    logic [8:0]            fl [1:8]; // flags of the current pattern
    int                    n_errors = 0;
    int                    comparisons = 0;
    int                    cycles = 0;
    int                    c0;
    logic [39:0]           held;

    always #10 clk_i = ~clk_i;
    vpsq_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .load_valid_i(load_valid_i),
        .load_i(load_i), .pat_clear_i(pat_clear_i), .loop_count_i(loop_count_i),
        .src_i(src_i), .clk_src_i(clk_src_i), .freq_div_i(freq_div_i), .wait_i(wait_i),
        .start_i(start_i), .start_index_i(start_index_i), .pins_o(pins_o),
        .pins_oe_o(pins_oe_o), .capture_o(capture_o), .busy_o(busy_o), .done_o(done_o),
        .start_err_o(start_err_o), .pattern_err_o(pattern_err_o));
    vpsq_uut_model uut (.clk_i(clk_i), .pins_i(pins_o), .pins_oe_i(pins_oe_o),
        .capture_i(capture_o), .wait_o(wait_i), .bus_o(bus));

    //==========================================================
    // helpers
    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    function automatic logic [39:0] lvl(input int idx);
        return {2'b00, idx[13:0], 10'h000, idx[13:0]};
    endfunction : lvl
    // expected board view: tri-state vectors float the middle pins
    function automatic logic [39:0] exp_bus(input int idx);
        logic [39:0] e;
        e = lvl(idx);
        if (fl[idx][0]) begin
            for (int b = 16; b < 32; b++) e[b] = 1'bz;
        end
        return e;
    endfunction : exp_bus
    // forget the old pattern, then load vectors 1..n back to back
    task automatic load_pat(input int n);
        @(negedge clk_i) pat_clear_i = 1'b1;
        @(negedge clk_i) pat_clear_i = 1'b0;
        for (int i = 1; i <= n; i++) begin
            @(negedge clk_i);
            load_valid_i = 1'b1;
            load_i = '0;
            load_i.index = 14'(i);
            load_i.vec.level = lvl(i);
            load_i.vec.drive = fl[i][0] ? 40'hff_0000_ffff : 40'hff_ffff_ffff;
            {load_i.loop_first, load_i.loop_last, load_i.vec.stop} = fl[i][8:6];
            {load_i.vec.capture, load_i.vec.cap_on, load_i.vec.cap_off} = fl[i][5:3];
            {load_i.vec.wait_mark, load_i.wait_rise} = fl[i][2:1];
        end
        @(negedge clk_i) load_valid_i = 1'b0;
    endtask : load_pat
    // start request; answer is due one edge after it is taken
    task automatic go(input logic [13:0] idx, input logic [16:0] cnt, input bit ok);
        @(negedge clk_i);
        start_index_i = idx;
        loop_count_i = cnt;
        start_i = 1'b1;
        @(negedge clk_i) start_i = 1'b0;
        check(busy_o === ok && start_err_o === !ok, "start answer wrong");
        c0 = uut.cap_count;
    endtask : go
    // one rising and falling edge of the selected drive clock
    task automatic adv(input vpsq_pkg::vpsq_src_e s);
        for (int v = 1; v >= 0; v--) begin
            @(negedge clk_i);
            case (s)
                vpsq_pkg::SRC_DRCLK: clk_src_i.drclk = v[0];
                vpsq_pkg::SRC_POD:   clk_src_i.pod = v[0];
                default:             clk_src_i.step = v[0];
            endcase
            repeat (2) @(negedge clk_i);
        end
    endtask : adv
    // step through the expected order, then check the stop and hold
    task automatic run(input int q[$]);
        foreach (q[k]) begin
            adv(vpsq_pkg::SRC_STEP);
            check(bus === exp_bus(q[k]), "wrong vector driven");
        end
        check(done_o === 1'b1 && busy_o === 1'b0, "no completion");
        adv(vpsq_pkg::SRC_STEP);
        check(bus === exp_bus(q[$]), "pins moved after finish");
    endtask : run

    //==========================================================
    // scenarios
    task automatic s_loops();
        fl = '{default: 9'h000};
        fl[2] = F_LF | F_CAP;
        fl[3] = F_TRI;
        fl[4] = F_LL | F_STP;
        load_pat(6);
        go(14'h0001, 17'h0_0002, 1'b1);
        run('{1, 2, 3, 4, 2, 3, 4});
        check(uut.cap_count - c0 == 2, "capture count");
        go(14'h0001, 17'h0_0001, 1'b1);
        run('{1, 2, 3, 4});
        go(14'h0003, 17'h0_0002, 1'b1);
        run('{3, 4, 2, 3, 4});
    endtask : s_loops
    task automatic s_refuse();
        logic [30:0] bad [4];
        bad = '{{14'h0000, 17'h0_0001}, {14'h2001, 17'h0_0001},
                {14'h0007, 17'h0_0001}, {14'h0001, 17'h1_0001}};
        foreach (bad[k]) go(bad[k][30:17], bad[k][16:0], 1'b0);
        go(14'h0001, 17'h0_0000, 1'b0);
        fl[2] = F_LF | F_LL;
        load_pat(4);
        go(14'h0001, 17'h0_0001, 1'b0);
        fl[4] = 9'h000;
        load_pat(4);
        go(14'h0001, 17'h0_0001, 1'b0);
        fl = '{default: 9'h000};
        fl[1] = F_WM | F_WR;
        fl[3] = F_WM;
        load_pat(4);
        go(14'h0001, 17'h0_0001, 1'b0);
        @(negedge clk_i) pat_clear_i = 1'b1;
        @(negedge clk_i);
        pat_clear_i = 1'b0;
        check(pattern_err_o === 1'b0, "error not cleared");
        load_valid_i = 1'b1;
        load_i.index = 14'h0000;
        @(negedge clk_i) load_valid_i = 1'b0;
        @(negedge clk_i) check(pattern_err_o === 1'b1, "index 0 accepted");
    endtask : s_refuse
    task automatic s_capture();
        fl = '{default: 9'h000};
        fl[1] = F_CAP | F_CON;
        fl[4] = F_COF;
        load_pat(5);
        go(14'h0001, 17'h1_0000, 1'b1);
        run('{1, 2, 3, 4, 5});
        check(uut.cap_count - c0 == 3, "capture run count");
    endtask : s_capture
    // rising wait first, then falling wait, pause line ends low
    task automatic s_wait();
        for (int p = 1; p >= 0; p--) begin
            fl = '{default: 9'h000};
            fl[2] = p[0] ? (F_WM | F_WR) : F_WM;
            load_pat(3);
            go(14'h0001, 17'h0_0001, 1'b1);
            adv(vpsq_pkg::SRC_STEP);
            adv(vpsq_pkg::SRC_STEP);
            check(bus === exp_bus(1), "advanced through pause");
            uut.flip_wait();
            run('{2, 3});
        end
    endtask : s_wait
    task automatic s_sources();
        fl = '{default: 9'h000};
        fl[1] = F_CAP;
        load_pat(3);
        src_i = vpsq_pkg::SRC_DRCLK;
        go(14'h0001, 17'h0_0001, 1'b1);
        held = bus;
        adv(vpsq_pkg::SRC_DRCLK);
        check(bus === held, "moved without qualifier");
        clk_src_i.enable = 1'b1;
        adv(vpsq_pkg::SRC_DRCLK);
        check(bus === exp_bus(1) && uut.cap_count - c0 == 1, "drclk drive");
        src_i = vpsq_pkg::SRC_POD;
        adv(vpsq_pkg::SRC_POD);
        check(bus === exp_bus(2), "pod drive");
        @(negedge clk_i) clk_src_i.enable = 1'b0;
        src_i = vpsq_pkg::SRC_INTFREQ;
        repeat (40) @(negedge clk_i);
        check(bus === exp_bus(2), "generator ran unqualified");
        clk_src_i.enable = 1'b1;
        for (int t = 0; t < 60 && done_o !== 1'b1; t++) @(negedge clk_i);
        check(bus === exp_bus(3) && done_o === 1'b1, "generator drive");
        src_i = vpsq_pkg::SRC_STEP;
    endtask : s_sources

    //==========================================================
    // verdict and hang guard
    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        s_loops();
        s_refuse();
        s_capture();
        s_wait();
        s_sources();
        summarize();
    end
endmodule : test_vector_pattern_sequencer
